// [pwm_pair_combine_control.v]
`timescale 1ns/100ps
`default_nettype none
`include "pair_combine_consts.vh"

// Contract
// - Fault enable set applies fault control to channels 2 and 3; clear ignores faults.
// - Bit 13 enables synchronized updates of the pair's channel value registers.
// - Bit 12 enables deadtime insertion between channel 2 and 3 outputs.
// - Deadtime, dual mode, complement, join and fault bits write only when unprotected.
// - Bit 11 arms dual capture; effective only with enhanced features and dual mode.
// - In one-shot dual capture, hardware clears the arm after channel 3 capture.
// - Bit 10 enables dual capture mode, reinterpreting mode bits, needs enhanced features.
// - Bit 9 makes channel 3 the inverse of channel 2 when combined.
// - Join enable combines channels 2 and 3; clear keeps them independent.
module pwm_pair_combine_control (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst,
    // Register write port for the pair field group
    input wire i_field_wr,
    input wire [`PAIR_FIELD_WIDTH-1:0] i_field_wdata,
    // Global mode bits
    input wire i_write_protection_disable,
    input wire i_enhanced_feature_enable,
    // Capture and channel activity
    input wire i_dual_capture_one_shot,
    input wire i_ch3_capture_event,
    input wire i_ch2_out,
    input wire i_fault_active,
    // Readback of the field group
    output reg [`PAIR_FIELD_WIDTH-1:0] o_field_rdata,
    // Pair enables towards the channel logic
    output reg o_fault_control_active,
    output reg o_value_sync_active,
    output reg o_deadtime_active,
    output reg o_dual_capture_mode_active,
    output reg o_dual_capture_armed,
    output reg o_mode_bits_reinterpreted,
    output reg o_pair_joined,
    output reg o_ch3_out,
    output reg o_pair_fault_hold
);
    // Stored settings, straight from their flip-flops.
    wire pair_fault_enable;
    wire pair_value_sync_enable;
    wire pair_deadtime_enable;
    wire pair_dual_capture_arm;
    wire pair_dual_capture_mode_enable;
    wire pair_complement_enable;
    wire pair_join_enable;
    wire protected_wr_allow;
    wire wr_fault_bit;
    wire wr_sync_bit;
    wire wr_deadtime_bit;
    wire wr_arm_bit;
    wire wr_dual_mode_bit;
    wire wr_complement_bit;
    wire wr_join_bit;
    wire dual_mode_live;
    wire one_shot_done;
    wire arm_clear;
    wire [`PAIR_FIELD_WIDTH-1:0] field_image_d;
    wire fault_hold_d;
    wire dual_armed_d;
    wire ch3_out_d;

    // The five protected settings share one gate, so they always lock and unlock together.
    assign protected_wr_allow = i_write_protection_disable;

    // Each setting reads its own lane of the write word; moving a field only touches the header.
    assign wr_fault_bit = i_field_wdata[`PAIR_FAULT_BIT-`PAIR_FIELD_LSB];
    assign wr_sync_bit = i_field_wdata[`PAIR_SYNC_BIT-`PAIR_FIELD_LSB];
    assign wr_deadtime_bit = i_field_wdata[`PAIR_DEADTIME_BIT-`PAIR_FIELD_LSB];
    assign wr_arm_bit = i_field_wdata[`PAIR_DUAL_ARM_BIT-`PAIR_FIELD_LSB];
    assign wr_dual_mode_bit = i_field_wdata[`PAIR_DUAL_MODE_BIT-`PAIR_FIELD_LSB];
    assign wr_complement_bit = i_field_wdata[`PAIR_COMPLEMENT_BIT-`PAIR_FIELD_LSB];
    assign wr_join_bit = i_field_wdata[`PAIR_JOIN_BIT-`PAIR_FIELD_LSB];

    assign dual_mode_live = i_enhanced_feature_enable & pair_dual_capture_mode_enable;
    assign one_shot_done = i_dual_capture_one_shot & i_ch3_capture_event;
    // The hardware clear of the arm only fires when a one-shot sequence really finished while armed and live.
    assign arm_clear = dual_mode_live & pair_dual_capture_arm & one_shot_done;

    // One stored bit per setting; only the arm has a hardware clear.
    pair_setting_bit u_fault (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_en(i_field_wr),
        .i_wr_bit(wr_fault_bit),
        .i_wr_allow(protected_wr_allow),
        .i_hw_clear(1'h0),
        .o_bit(pair_fault_enable)
    );

    // The sync enable is not write protected.
    pair_setting_bit u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_en(i_field_wr),
        .i_wr_bit(wr_sync_bit),
        .i_wr_allow(1'h1),
        .i_hw_clear(1'h0),
        .o_bit(pair_value_sync_enable)
    );

    pair_setting_bit u_deadtime (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_en(i_field_wr),
        .i_wr_bit(wr_deadtime_bit),
        .i_wr_allow(protected_wr_allow),
        .i_hw_clear(1'h0),
        .o_bit(pair_deadtime_enable)
    );

    // The arm bit is not write protected, but hardware may clear it.
    pair_setting_bit u_arm (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_en(i_field_wr),
        .i_wr_bit(wr_arm_bit),
        .i_wr_allow(1'h1),
        .i_hw_clear(arm_clear),
        .o_bit(pair_dual_capture_arm)
    );

    pair_setting_bit u_dual_mode (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_en(i_field_wr),
        .i_wr_bit(wr_dual_mode_bit),
        .i_wr_allow(protected_wr_allow),
        .i_hw_clear(1'h0),
        .o_bit(pair_dual_capture_mode_enable)
    );

    pair_setting_bit u_complement (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_en(i_field_wr),
        .i_wr_bit(wr_complement_bit),
        .i_wr_allow(protected_wr_allow),
        .i_hw_clear(1'h0),
        .o_bit(pair_complement_enable)
    );

    pair_setting_bit u_join (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_en(i_field_wr),
        .i_wr_bit(wr_join_bit),
        .i_wr_allow(protected_wr_allow),
        .i_hw_clear(1'h0),
        .o_bit(pair_join_enable)
    );

    // Readback image, built lane by lane in the same order as the write word.
    assign field_image_d[`PAIR_FAULT_BIT-`PAIR_FIELD_LSB] = pair_fault_enable;
    assign field_image_d[`PAIR_SYNC_BIT-`PAIR_FIELD_LSB] = pair_value_sync_enable;
    assign field_image_d[`PAIR_DEADTIME_BIT-`PAIR_FIELD_LSB] = pair_deadtime_enable;
    assign field_image_d[`PAIR_DUAL_ARM_BIT-`PAIR_FIELD_LSB] = pair_dual_capture_arm;
    assign field_image_d[`PAIR_DUAL_MODE_BIT-`PAIR_FIELD_LSB] = pair_dual_capture_mode_enable;
    assign field_image_d[`PAIR_COMPLEMENT_BIT-`PAIR_FIELD_LSB] = pair_complement_enable;
    assign field_image_d[`PAIR_JOIN_BIT-`PAIR_FIELD_LSB] = pair_join_enable;

    assign fault_hold_d = pair_fault_enable & i_fault_active;
    // The arm is reported only while dual capture is live, since it has no effect otherwise.
    assign dual_armed_d = dual_mode_live & pair_dual_capture_arm;
    // Outside combined operation channel 3 follows its own path, so this copy stays low.
    assign ch3_out_d = pair_join_enable & (i_ch2_out ^ pair_complement_enable);

    // Outputs are registered, so each reflects the stored bits one cycle after they change.
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_field_rdata <= `PAIR_FIELD_RESET;
        end else begin
            o_field_rdata <= field_image_d;
        end
    end

    // Fault, sync and deadtime enables go to their channel logic unchanged.
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_fault_control_active <= `PAIR_SETTING_RESET;
            o_pair_fault_hold <= `PAIR_SETTING_RESET;
            o_value_sync_active <= `PAIR_SETTING_RESET;
            o_deadtime_active <= `PAIR_SETTING_RESET;
        end else begin
            o_fault_control_active <= pair_fault_enable;
            o_pair_fault_hold <= fault_hold_d;
            o_value_sync_active <= pair_value_sync_enable;
            o_deadtime_active <= pair_deadtime_enable;
        end
    end

    // Capture settings only count while enhanced features are on.
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_dual_capture_mode_active <= `PAIR_SETTING_RESET;
            o_mode_bits_reinterpreted <= `PAIR_SETTING_RESET;
            o_dual_capture_armed <= `PAIR_SETTING_RESET;
        end else begin
            o_dual_capture_mode_active <= dual_mode_live;
            o_mode_bits_reinterpreted <= dual_mode_live;
            o_dual_capture_armed <= dual_armed_d;
        end
    end

    // Combined operation of the pair.
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pair_joined <= `PAIR_SETTING_RESET;
            o_ch3_out <= `PAIR_SETTING_RESET;
        end else begin
            o_pair_joined <= pair_join_enable;
            o_ch3_out <= ch3_out_d;
        end
    end
endmodule // pwm_pair_combine_control

`default_nettype wire

// [pair_combine_consts.vh]
`ifndef PAIR_COMBINE_CONSTS_VH
`define PAIR_COMBINE_CONSTS_VH

// Bit positions of the pair field group inside the combine register word.
`define PAIR_JOIN_BIT 8
`define PAIR_COMPLEMENT_BIT 9
`define PAIR_DUAL_MODE_BIT 10
`define PAIR_DUAL_ARM_BIT 11
`define PAIR_DEADTIME_BIT 12
`define PAIR_SYNC_BIT 13
`define PAIR_FAULT_BIT 14
`define PAIR_FIELD_LSB 8
`define PAIR_FIELD_WIDTH 7

// Reset value of every setting.
`define PAIR_SETTING_RESET 1'h0
`define PAIR_FIELD_RESET 7'h00

`endif

// [pair_setting_bit.v]
`timescale 1ns/100ps
`default_nettype none
`include "pair_combine_consts.vh"

// One stored setting bit with an optional write gate and a hardware clear.
module pair_setting_bit (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst,
    // Software side
    input wire i_wr_en,
    input wire i_wr_bit,
    input wire i_wr_allow,
    // Hardware side
    input wire i_hw_clear,
    // State
    output reg o_bit
);
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_bit <= `PAIR_SETTING_RESET;
        end else if (i_wr_en && i_wr_allow) begin
            // A software write in the same cycle as a hardware clear wins, so an explicit re-arm is never lost.
            o_bit <= i_wr_bit;
        end else if (i_hw_clear) begin
            o_bit <= 1'h0;
        end
    end
endmodule // pair_setting_bit

`default_nettype wire

// [pair_combine_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module pair_combine_chk (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst,
    // Inputs
    input wire i_field_wr,
    input wire [6:0] i_field_wdata,
    input wire i_write_protection_disable,
    input wire i_enhanced_feature_enable,
    input wire i_dual_capture_one_shot,
    input wire i_ch3_capture_event,
    input wire i_ch2_out,
    input wire i_fault_active,
    // Outputs
    input wire [6:0] o_field_rdata,
    input wire o_fault_control_active,
    input wire o_value_sync_active,
    input wire o_deadtime_active,
    input wire o_dual_capture_mode_active,
    input wire o_dual_capture_armed,
    input wire o_mode_bits_reinterpreted,
    input wire o_pair_joined,
    input wire o_ch3_out,
    input wire o_pair_fault_hold
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_fault_hold_tie: assert property (o_fault_control_active == o_field_rdata[6] &&
        o_pair_fault_hold == (o_field_rdata[6] && $past(i_fault_active))) else $error("fault hold wrong");
    a_sync_follows: assert property (o_value_sync_active == o_field_rdata[5]) else $error("sync wrong");
    a_deadtime_follows: assert property (o_deadtime_active == o_field_rdata[4]) else $error("deadtime wrong");
    a_protect_holds: assert property (!i_field_wr || !i_write_protection_disable |=> ##1
        (o_field_rdata & 7'h57) == ($past(o_field_rdata) & 7'h57)) else $error("protected bit changed");
    a_write_lands: assert property (i_field_wr && i_write_protection_disable |=> ##1
        o_field_rdata == $past(i_field_wdata, 2)) else $error("write not stored");
    a_arm_gated: assert property (o_dual_capture_armed ==
        (o_field_rdata[3] && o_field_rdata[2] && $past(i_enhanced_feature_enable))) else $error("arm wrong");
    a_arm_autoclear: assert property (i_ch3_capture_event && i_dual_capture_one_shot && i_enhanced_feature_enable
        && !i_field_wr |=> ##1 !(o_field_rdata[3] && o_field_rdata[2])) else $error("arm not cleared");
    a_mode_gated: assert property (o_dual_capture_mode_active == (o_field_rdata[2] &&
        $past(i_enhanced_feature_enable)) && o_mode_bits_reinterpreted == o_dual_capture_mode_active)
        else $error("mode wrong");
    a_ch3_follows: assert property (o_pair_joined == o_field_rdata[0] && o_ch3_out ==
        (o_field_rdata[0] && ($past(i_ch2_out) ^ o_field_rdata[1]))) else $error("channel 3 wrong");
endmodule // pair_combine_chk
bind pwm_pair_combine_control pair_combine_chk pair_combine_chk_i (.*);
`default_nettype wire

// [test_pwm_pair_combine_control.sv]
`timescale 1ns/100ps
`default_nettype none
module test_pwm_pair_combine_control;
    logic i_core_clk = 0, i_rst = 1, i_field_wr = 0, i_write_protection_disable = 0, i_enhanced_feature_enable = 1;
    logic i_dual_capture_one_shot = 0, i_ch3_capture_event = 0, i_ch2_out = 0, i_fault_active = 0;
    logic [6:0] i_field_wdata = 7'h00, o_field_rdata;
    logic o_fault_control_active, o_value_sync_active, o_deadtime_active, o_dual_capture_mode_active;
    logic o_dual_capture_armed, o_mode_bits_reinterpreted, o_pair_joined, o_ch3_out, o_pair_fault_hold;
    int num_errors = 0, compares = 0;
    logic [6:0] d;
    pwm_pair_combine_control pwm_pair_combine_control_i (.*);
    always #10 i_core_clk = ~i_core_clk;
    task chk(input string n, input logic [6:0] e, input logic [6:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Called at a falling edge; returns once the result is visible.
    task wr(input logic [6:0] v, input logic wp);
        i_write_protection_disable = wp;
        i_field_wdata = v;
        i_field_wr = 1;
        @(negedge i_core_clk);
        i_field_wr = 0;
        repeat (2) @(negedge i_core_clk);
    endtask
    task t_write;
        for (int i = 0; i < 7; i++) begin
            d = 7'h01 << i;
            wr(d, 1);
            chk("rdata", d, o_field_rdata);
            chk("enables", {d[6:4], d[3] & d[2], d[2], d[2], d[0]}, {o_fault_control_active, o_value_sync_active,
                o_deadtime_active, o_dual_capture_armed, o_dual_capture_mode_active, o_mode_bits_reinterpreted,
                o_pair_joined});
        end
        i_enhanced_feature_enable = 0;
        wr(7'h0c, 1);
        chk("gated", 7'h00, {o_dual_capture_armed, o_dual_capture_mode_active, 5'h00});
        $display("write test done");
    endtask
    task t_protect;
        wr(7'h00, 1);
        wr(7'h7f, 0);
        chk("protected", 7'h28, o_field_rdata);
        wr(7'h7f, 1);
        chk("unprotected", 7'h7f, o_field_rdata);
        wr(7'h00, 0);
        chk("held", 7'h57, o_field_rdata);
        $display("protect test done");
    endtask
    task t_ch3;
        for (int i = 0; i < 4; i++) begin
            wr({6'h00, 1'b1} | {5'h00, i[1], 1'b0}, 1);
            i_ch2_out = i[0];
            repeat (2) @(negedge i_core_clk);
            chk("ch3", {6'h00, i[0] ^ i[1]}, {6'h00, o_ch3_out});
        end
        wr(7'h40, 1);
        i_fault_active = 1;
        repeat (2) @(negedge i_core_clk);
        chk("fault hold", 7'h01, {6'h00, o_pair_fault_hold});
        wr(7'h00, 1);
        chk("fault ignored", 7'h00, {6'h00, o_pair_fault_hold});
        i_fault_active = 0;
        $display("channel test done");
    endtask
    task t_clear;
        i_enhanced_feature_enable = 1;
        wr(7'h0c, 1);
        chk("armed", 7'h01, {6'h00, o_dual_capture_armed});
        for (int k = 0; k < 2; k++) begin
            i_dual_capture_one_shot = k[0];
            i_ch3_capture_event = 1;
            @(negedge i_core_clk);
            i_ch3_capture_event = 0;
            repeat (2) @(negedge i_core_clk);
            chk("autoclear", k ? 7'h04 : 7'h0c, o_field_rdata);
        end
        chk("armed", 7'h00, {6'h00, o_dual_capture_armed});
        $display("clear test done");
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge i_core_clk);
        i_rst = 0;
        t_write;
        t_protect;
        t_ch3;
        t_clear;
        summarize;
    end
endmodule // test_pwm_pair_combine_control
`default_nettype wire
